/* csf_params.svh */
// constants for the converter serial frame link
`ifndef CSF_PARAMS_SVH
`define CSF_PARAMS_SVH
`define CSF_WORD_BITS 16
`define CSF_FRAME_SLOTS 32
`define CSF_SLOT_MSB 15
`define CSF_LAST_SLOT 5'h1f
`define CSF_HALF_SLOT 5'h10
`define CSF_CLK_DIV 4
`define CSF_PHASE_RISE 2'h1
`define CSF_PHASE_FALL 2'h3
`define CSF_SETTLE_FRAMES 5'h1f
`define CSF_CONV_BITS 24
`define CSF_CONV_FRAC 8
`define CSF_CODE_MAX 16'h7fff
`define CSF_CODE_MIN 16'h8000
`define CSF_HOST_CLK_NS 10
`define CSF_SYNC_HIGH_NS 640
`define CSF_SYNC_HIGH_CYC ((`CSF_SYNC_HIGH_NS + `CSF_HOST_CLK_NS - 1) / `CSF_HOST_CLK_NS)
`endif

/* csf_pkg.sv */
// types shared by both ends of the converter serial frame link
package csf_pkg;
    typedef logic [15:0] csf_word_t;
    typedef logic [4:0] csf_slot_t;
    typedef enum logic [1:0] {
        CSF_SYNC_IDLE = 2'b01,
        CSF_SYNC_HIGH = 2'b10
    } csf_sync_state_t;
endpackage

/* csf_link_if.sv */
// pins between the converter end and the receiving end
`timescale 1ns/10ps
interface csf_link_if;
    logic bit_clock_out;
    logic frame_marker_out;
    logic serial_result_out;
    logic serial_result_oe;
    logic serial_line;
    logic frame_marker_in;
    logic serial_format_select;
    logic output_enable_pin;
    logic time_slot_select;

    // shared data line: released line reads as pulled low
    assign serial_line = serial_result_oe ? serial_result_out : 1'b0;

    modport dev (
        output bit_clock_out,
        output frame_marker_out,
        output serial_result_out,
        output serial_result_oe,
        input frame_marker_in,
        input serial_format_select,
        input output_enable_pin,
        input time_slot_select
    );
    modport host (
        input bit_clock_out,
        input frame_marker_out,
        input serial_line,
        output frame_marker_in,
        output serial_format_select,
        output output_enable_pin,
        output time_slot_select
    );
endinterface

/* csf_converter.sv */
// converter end: frame timing, result shifter, frame sync and data enable
`timescale 1ns/10ps
`include "csf_params.svh"

// Functional notes
// RULE1 - bit clock is input clock divided four
// RULE2 - frame lasts 32 bit clocks
// RULE3 - sixteen result bits, msb first
// RULE4 - second half of frame shifts zeroes
// RULE5 - format pin picks valid clock edge
// RULE6 - format low: one-slot sync before msb
// RULE7 - format high: sync square wave, period 32
// RULE8 - rising sync input restarts frame immediately
// RULE9 - 31 results unsettled after irregular resync
// RULE10 - free running frame without sync input
// RULE11 - disabled output releases data line
// RULE12 - enable active level equals slot pin
// RULE13 - master first half, slave second half
// RULE14 - straps choose master or slave role
// RULE15 - master sync drives enables, slave sync; receiver routes it to the enable pin only, not to the sync input
// RULE16 - result rounded and clamped to 16 bits
// RULE17 - data changes on opposite clock edge
module csf_converter (
    // link clock and reset
    input wire logic link_clock,
    input wire logic reset_n,
    // link pins
    csf_link_if.dev link,
    // conversion result, signed with fraction bits
    input wire logic signed [`CSF_CONV_BITS-1:0] conv_value,
    // status
    output logic conv_unsettled
);
    import csf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] fsi_sync_reg;
    logic fsi_prev_reg;
    logic [1:0] fmt_sync_reg;
    logic [1:0] oe_sync_reg;
    logic [1:0] slot_sync_reg;
    logic fmt;
    logic fsi_rise;

    // frame sync input is caught on falling clock edges
    always_ff @(negedge link_clock or negedge reset_n) begin
        if (!reset_n) begin
            fsi_sync_reg <= 2'h0;
            fsi_prev_reg <= 1'b0;
        end else begin
            fsi_sync_reg <= {fsi_sync_reg[0], link.frame_marker_in};
            fsi_prev_reg <= fsi_sync_reg[1];
        end
    end

    always_ff @(posedge link_clock or negedge reset_n) begin
        if (!reset_n) begin
            fmt_sync_reg <= 2'h0;
            oe_sync_reg <= 2'h0;
            slot_sync_reg <= 2'h0;
        end else begin
            fmt_sync_reg <= {fmt_sync_reg[0], link.serial_format_select};
            oe_sync_reg <= {oe_sync_reg[0], link.output_enable_pin};
            slot_sync_reg <= {slot_sync_reg[0], link.time_slot_select};
        end
    end

    assign fmt = fmt_sync_reg[1];
    // low-to-high between adjacent falling edges
    assign fsi_rise = fsi_sync_reg[1] & ~fsi_prev_reg; // RULE8

    ////////////////////////////////////////////////////////////////////////
    // result rounding and clamping
    localparam int CONV_INT = `CSF_CONV_BITS - `CSF_CONV_FRAC;
    logic signed [CONV_INT:0] rounded;
    csf_word_t code;

    always_comb begin
        rounded = (CONV_INT + 1)'(conv_value >>> `CSF_CONV_FRAC)
            + (CONV_INT + 1)'(conv_value[`CSF_CONV_FRAC-1]); // RULE16
        if (rounded > $signed((CONV_INT + 1)'(`CSF_CODE_MAX))) begin
            code = `CSF_CODE_MAX; // RULE16
        end else if (rounded < -$signed((CONV_INT + 1)'(`CSF_CODE_MIN))) begin
            code = `CSF_CODE_MIN; // RULE16
        end else begin
            code = rounded[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bit clock divider and slot counter
    logic [1:0] phase_reg;
    csf_slot_t slot_reg;
    logic sco_reg;
    logic at_fall;
    logic at_rise;
    logic frame_end;
    logic resync;

    assign at_rise = (phase_reg == `CSF_PHASE_RISE);
    assign at_fall = (phase_reg == `CSF_PHASE_FALL);
    assign frame_end = at_fall && (slot_reg == `CSF_LAST_SLOT);
    // a sync landing exactly on the natural frame end is not counted as a resync
    assign resync = fsi_rise && !frame_end;

    always_ff @(posedge link_clock or negedge reset_n) begin
        if (!reset_n) begin
            phase_reg <= 2'h0;
        end else if (fsi_rise) begin
            phase_reg <= 2'h0; // RULE8
        end else begin
            phase_reg <= phase_reg + 2'h1; // RULE1
        end
    end

    always_ff @(posedge link_clock or negedge reset_n) begin
        if (!reset_n) begin
            sco_reg <= 1'b0;
        end else if (fsi_rise) begin
            sco_reg <= 1'b0;
        end else if (at_rise) begin
            sco_reg <= 1'b1; // RULE1
        end else if (at_fall) begin
            sco_reg <= 1'b0; // RULE1
        end
    end

    // wraps by itself so frames run with a steady sync input
    always_ff @(posedge link_clock or negedge reset_n) begin
        if (!reset_n) begin
            slot_reg <= 5'h0;
        end else if (fsi_rise) begin
            slot_reg <= 5'h0; // RULE8
        end else if (at_fall) begin
            slot_reg <= slot_reg + 5'h1; // RULE2 RULE10
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // word latch and bit selection
    csf_word_t word_reg;
    csf_slot_t next_slot;
    csf_slot_t load_slot;
    logic load_now;
    logic new_frame;
    logic data_bit;

    assign next_slot = slot_reg + 5'h1;
    assign new_frame = fsi_rise || frame_end;
    // format high: change at falling edge, valid at rising; low: reverse
    assign load_now = fmt ? at_fall : at_rise; // RULE5 RULE17
    assign load_slot = fmt ? next_slot : slot_reg;

    always_ff @(posedge link_clock or negedge reset_n) begin
        if (!reset_n) begin
            word_reg <= 16'h0000;
        end else if (new_frame) begin
            word_reg <= code; // RULE2
        end
    end

    always_comb begin
        if (load_slot < `CSF_HALF_SLOT) begin
            data_bit = word_reg[`CSF_SLOT_MSB - load_slot[3:0]]; // RULE3
        end else begin
            data_bit = 1'b0; // RULE4
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data and frame sync outputs
    logic sdo_reg;
    logic fso_reg;

    always_ff @(posedge link_clock or negedge reset_n) begin
        if (!reset_n) begin
            sdo_reg <= 1'b0;
        end else if (new_frame && fmt) begin
            sdo_reg <= code[`CSF_SLOT_MSB]; // RULE3
        end else if (fsi_rise) begin
            sdo_reg <= 1'b0;
        end else if (load_now) begin
            sdo_reg <= data_bit; // RULE17
        end
    end

    always_ff @(posedge link_clock or negedge reset_n) begin
        if (!reset_n) begin
            fso_reg <= 1'b0;
        end else if (new_frame && fmt) begin
            fso_reg <= 1'b0; // RULE7
        end else if (fsi_rise) begin
            fso_reg <= 1'b0;
        end else if (load_now) begin
            if (fmt) begin
                fso_reg <= (load_slot >= `CSF_HALF_SLOT); // RULE7
            end else begin
                fso_reg <= (load_slot == `CSF_LAST_SLOT); // RULE6
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output enable: drive while enable pin equals slot pin
    logic drive_reg;

    always_ff @(posedge link_clock or negedge reset_n) begin
        if (!reset_n) begin
            drive_reg <= 1'b0;
        end else begin
            drive_reg <= (oe_sync_reg[1] == slot_sync_reg[1]); // RULE11 RULE12 RULE13
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // settling count after an irregular frame sync
    logic [4:0] settle_reg;

    always_ff @(posedge link_clock or negedge reset_n) begin
        if (!reset_n) begin
            settle_reg <= 5'h0;
        end else if (resync) begin
            settle_reg <= `CSF_SETTLE_FRAMES; // RULE9
        end else if (frame_end && settle_reg != 5'h0) begin
            settle_reg <= settle_reg - 5'h1; // RULE9
        end
    end

    assign conv_unsettled = (settle_reg != 5'h0);
    assign link.bit_clock_out = sco_reg;
    assign link.frame_marker_out = fso_reg;
    assign link.serial_result_out = sdo_reg;
    assign link.serial_result_oe = drive_reg; // RULE11
endmodule

/* csf_receiver.sv */
// receiving end: straps, frame sync request and word capture
`timescale 1ns/10ps
`include "csf_params.svh"

module csf_receiver (
    // system clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // link pins
    csf_link_if.host link,
    // configuration
    input wire logic cfg_format_high,
    input wire logic cfg_slave,
    input wire logic cfg_shared,
    input wire logic cfg_line_enable,
    // frame sync request
    input wire logic sync_req,
    output logic sync_busy,
    // received words
    output csf_pkg::csf_word_t rx_word,
    output logic rx_valid,
    output logic rx_unsettled
);
    import csf_pkg::*;

    localparam int SYNC_CYC = `CSF_SYNC_HIGH_CYC;

    ////////////////////////////////////////////////////////////////////////
    // straps and enable pin
    logic fmt_reg;
    logic slot_reg;
    logic oe_pin_reg;
    logic [1:0] sck_sync_reg;
    logic [1:0] fso_sync_reg;
    logic [1:0] dat_sync_reg;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fmt_reg <= 1'b0;
            slot_reg <= 1'b0;
        end else begin
            fmt_reg <= cfg_shared | cfg_format_high; // RULE14
            slot_reg <= cfg_shared & cfg_slave; // RULE14
        end
    end

    // shared mode passes the master frame sync to the enable pin
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            oe_pin_reg <= 1'b1;
        end else if (cfg_shared) begin
            oe_pin_reg <= fso_sync_reg[1]; // RULE15
        end else begin
            oe_pin_reg <= cfg_line_enable ? slot_reg : ~slot_reg; // RULE12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sck_sync_reg <= 2'h0;
            fso_sync_reg <= 2'h0;
            dat_sync_reg <= 2'h0;
        end else begin
            sck_sync_reg <= {sck_sync_reg[0], link.bit_clock_out};
            fso_sync_reg <= {fso_sync_reg[0], link.frame_marker_out};
            dat_sync_reg <= {dat_sync_reg[0], link.serial_line};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frame sync request pulse, held over several converter clock falls
    csf_sync_state_t sync_state_reg;
    logic [$clog2(SYNC_CYC+1)-1:0] sync_cnt_reg;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sync_state_reg <= CSF_SYNC_IDLE;
            sync_cnt_reg <= '0;
        end else begin
            case (sync_state_reg)
                CSF_SYNC_IDLE: begin
                    if (sync_req && !cfg_shared) begin
                        sync_state_reg <= CSF_SYNC_HIGH; // RULE8
                        sync_cnt_reg <= ($clog2(SYNC_CYC+1))'(SYNC_CYC - 1);
                    end
                end
                CSF_SYNC_HIGH: begin
                    if (sync_cnt_reg == '0) begin
                        sync_state_reg <= CSF_SYNC_IDLE;
                    end else begin
                        sync_cnt_reg <= sync_cnt_reg - 1'b1;
                    end
                end
                default: begin
                    sync_state_reg <= CSF_SYNC_IDLE;
                end
            endcase
        end
    end

    assign sync_busy = (sync_state_reg == CSF_SYNC_HIGH);

    ////////////////////////////////////////////////////////////////////////
    // word capture on the valid edge
    logic sck_prev_reg;
    logic fso_prev_reg;
    logic sample;
    logic start;
    logic [4:0] bit_cnt_reg;
    csf_word_t shift_reg;
    csf_word_t word_reg;
    logic valid_reg;
    logic [4:0] settle_reg;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sck_prev_reg <= 1'b0;
        end else begin
            sck_prev_reg <= sck_sync_reg[1];
        end
    end

    assign sample = fmt_reg ? (sck_sync_reg[1] & ~sck_prev_reg)
                            : (~sck_sync_reg[1] & sck_prev_reg); // RULE5
    // sync was high in the slot before the msb
    assign start = sample && fso_prev_reg && !fso_sync_reg[1]; // RULE6 RULE7

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fso_prev_reg <= 1'b0;
            bit_cnt_reg <= 5'h0;
            shift_reg <= 16'h0000;
        end else if (sample) begin
            fso_prev_reg <= fso_sync_reg[1];
            shift_reg <= {shift_reg[14:0], dat_sync_reg[1]}; // RULE3
            if (start) begin
                bit_cnt_reg <= 5'h1;
            end else if (bit_cnt_reg != 5'h0 && bit_cnt_reg != `CSF_HALF_SLOT) begin
                bit_cnt_reg <= bit_cnt_reg + 5'h1;
            end else begin
                bit_cnt_reg <= 5'h0;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            word_reg <= 16'h0000;
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= sample && bit_cnt_reg == `CSF_HALF_SLOT;
            if (sample && bit_cnt_reg == `CSF_HALF_SLOT) begin
                word_reg <= shift_reg; // RULE3
            end
        end
    end

    // results after our own frame sync are not trusted for 31 frames
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            settle_reg <= 5'h0;
        end else if (sync_req && sync_state_reg == CSF_SYNC_IDLE && !cfg_shared) begin
            settle_reg <= `CSF_SETTLE_FRAMES; // RULE9
        end else if (valid_reg && settle_reg != 5'h0) begin
            settle_reg <= settle_reg - 5'h1; // RULE9
        end
    end

    assign rx_word = word_reg;
    assign rx_valid = valid_reg;
    assign rx_unsettled = (settle_reg != 5'h0);
    assign link.serial_format_select = fmt_reg;
    assign link.time_slot_select = slot_reg;
    assign link.output_enable_pin = oe_pin_reg;
    assign link.frame_marker_in = sync_busy;
endmodule

/* csf_link_props.sv */
// link checker: frame timing, sync shape, data edges and line enable
`timescale 1ns/10ps
module csf_link_props (
    // link clock and reset
    input wire logic link_clock,
    input wire logic reset_n,
    // converter outputs
    input wire logic bit_clock_out,
    input wire logic frame_marker_out,
    input wire logic serial_result_out,
    input wire logic serial_result_oe,
    // receiver outputs
    input wire logic frame_marker_in,
    input wire logic serial_format_select,
    input wire logic output_enable_pin,
    input wire logic time_slot_select
);
    logic marker_reg;
    logic sync_in_reg;
    logic format_reg;
    logic [7:0] run_reg;
    logic [8:0] quiet_reg;
    logic quiet;

    default clocking link_cb @(posedge link_clock);
    endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////
    // length of the current marker level, in link clocks
    always_ff @(posedge link_clock or negedge reset_n) begin
        if (!reset_n) begin
            marker_reg <= 1'b0;
            run_reg <= 8'h00;
        end else begin
            marker_reg <= frame_marker_out;
            if (frame_marker_out != marker_reg)
                run_reg <= 8'h01;
            else if (run_reg != 8'hff)
                run_reg <= run_reg + 8'h01;
        end
    end

    // shape judged only well clear of a resync or format change
    always_ff @(posedge link_clock or negedge reset_n) begin
        if (!reset_n) begin
            sync_in_reg <= 1'b0;
            format_reg <= 1'b0;
            quiet_reg <= 9'h000;
        end else begin
            sync_in_reg <= frame_marker_in;
            format_reg <= serial_format_select;
            if ((frame_marker_in && !sync_in_reg) || serial_format_select != format_reg)
                quiet_reg <= 9'h000;
            else if (quiet_reg != 9'h1ff)
                quiet_reg <= quiet_reg + 9'h001;
        end
    end
    assign quiet = quiet_reg > 9'h12c;

    ////////////////////////////////////////////////////////////
    sequence bit_clock_rest;
        bit_clock_out ##1 !bit_clock_out [*2] ##1 bit_clock_out;
    endsequence
    sequence frame_restarted;
        ##[1:12] !frame_marker_out [*8];
    endsequence

    chk_bit_clock_ratio: assert property ($rose(bit_clock_out) && quiet |-> ##1 bit_clock_rest)
        else $error("bit clock is not a quarter of link clock");
    chk_sync_high_len: assert property ($fell(frame_marker_out) && quiet
        |-> run_reg == (serial_format_select ? 8'h40 : 8'h04))
        else $error("frame marker high length wrong");
    chk_sync_low_len: assert property ($rose(frame_marker_out) && quiet
        |-> run_reg == (serial_format_select ? 8'h40 : 8'h7c))
        else $error("frame marker low length wrong");
    chk_pad_zeroes: assert property (frame_marker_out && quiet |-> !serial_result_out)
        else $error("data not zero in pad slots");
    chk_data_edge: assert property ($changed(serial_result_out) && quiet
        |-> (serial_format_select ? $fell(bit_clock_out) : $rose(bit_clock_out)))
        else $error("data changed on the valid edge");
    chk_restart_frame: assert property ($rose(frame_marker_in) && serial_format_select |-> frame_restarted)
        else $error("sync input did not restart frame");
    chk_drive_enabled: assert property ((output_enable_pin == time_slot_select) [*6] |-> serial_result_oe)
        else $error("enabled line not driven");
    chk_drive_released: assert property ((output_enable_pin != time_slot_select) [*6] |-> !serial_result_oe)
        else $error("disabled line still driven");
endmodule

/* test_converter_serial_frame_output.sv */
// bench: converter and receiver joined over the link
`timescale 1ns/10ps
`include "csf_params.svh"
module test_converter_serial_frame_output;
    import csf_pkg::*;
    logic clock = 1'b0;
    logic link_clock = 1'b0;
    logic reset_n = 1'b0;
    logic signed [`CSF_CONV_BITS-1:0] conv_value = 24'h000000;
    logic conv_unsettled;
    logic cfg_format_high = 1'b0;
    logic cfg_slave = 1'b0;
    logic cfg_shared = 1'b0;
    logic cfg_line_enable = 1'b1;
    logic sync_req = 1'b0;
    logic sync_busy;
    csf_word_t rx_word;
    logic rx_valid;
    logic rx_unsettled;
    logic [15:0] wire_bits = 16'h0000;
    logic [15:0] wire_word = 16'h0000;
    int num_errors = 0;
    int n_compared = 0;
    int frame_count = 0;
    int sync_mark = 0;

    csf_link_if link_bus ();
    csf_converter csf_converter_i (.link_clock(link_clock), .reset_n(reset_n), .link(link_bus),
        .conv_value(conv_value), .conv_unsettled(conv_unsettled));
    csf_receiver csf_receiver_i (.clock(clock), .reset_n(reset_n), .link(link_bus),
        .cfg_format_high(cfg_format_high), .cfg_slave(cfg_slave), .cfg_shared(cfg_shared),
        .cfg_line_enable(cfg_line_enable), .sync_req(sync_req), .sync_busy(sync_busy),
        .rx_word(rx_word), .rx_valid(rx_valid), .rx_unsettled(rx_unsettled));
    csf_link_props csf_link_props_i (.link_clock(link_clock), .reset_n(reset_n),
        .bit_clock_out(link_bus.bit_clock_out), .frame_marker_out(link_bus.frame_marker_out),
        .serial_result_out(link_bus.serial_result_out), .serial_result_oe(link_bus.serial_result_oe),
        .frame_marker_in(link_bus.frame_marker_in), .serial_format_select(link_bus.serial_format_select),
        .output_enable_pin(link_bus.output_enable_pin), .time_slot_select(link_bus.time_slot_select));

    always #5 clock = ~clock;
    // link clock offset so its edges never line up with the system clock
    initial begin
        #3.3;
        forever #80 link_clock = ~link_clock;
    end

    ////////////////////////////////////////////////////////////
    // wire-side capture, meaningful with data valid on the rising edge
    always @(posedge link_bus.bit_clock_out)
        wire_bits <= {wire_bits[14:0], link_bus.serial_line};
    always @(posedge link_bus.frame_marker_out) begin
        frame_count <= frame_count + 1;
        wire_word <= wire_bits;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        n_compared++;
        if (seen !== expected) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, expected);
        end
    endtask

    task automatic report_and_stop();
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic expired();
        num_errors++;
        $display("BAD %0t wait ran out", $time);
        report_and_stop();
    endtask

    // edge of the frame marker to lvl; cycles counts clocks spent
    task automatic wait_marker(input logic lvl, output int cycles);
        cycles = 0;
        while (link_bus.frame_marker_out === lvl) begin
            @(negedge clock);
            cycles++;
            if (cycles > 3000) expired();
        end
        while (link_bus.frame_marker_out !== lvl) begin
            @(negedge clock);
            cycles++;
            if (cycles > 6000) expired();
        end
    endtask

    task automatic wait_rx();
        int n = 0;
        do begin
            @(negedge clock);
            n++;
            if (n > 5000) expired();
        end while (rx_valid !== 1'b1);
    endtask

    ////////////////////////////////////////////////////////////
    task automatic free_frames();
        int cycles;
        wait_marker(1'b1, cycles);
        wait_marker(1'b1, cycles);
        check(cycles >= 2047 && cycles <= 2049, 1);
    endtask

    task automatic enable_levels();
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            cfg_slave <= i[0];
            cfg_line_enable <= i[1];
            repeat (160) @(posedge clock);
            @(negedge clock);
            // slot strap follows cfg_slave only in shared mode
            check(link_bus.time_slot_select, 1'b0);
            check(link_bus.serial_result_oe, i[1]);
            if (!i[1])
                check(link_bus.serial_line, 0);
        end
        @(posedge clock);
        cfg_slave <= 1'b0;
    endtask

    // value latched at the next frame start; half-up rounding, clamped
    task automatic word_check(input logic signed [23:0] v, input logic on_wire);
        logic signed [24:0] r;
        logic [15:0] want;
        int c;
        r = ($signed({v[23], v}) + 25'sh80) >>> 8;
        if (r > 25'sh7fff)
            want = 16'h7fff;
        else if (r < -25'sh8000)
            want = 16'h8000;
        else
            want = r[15:0];
        @(posedge link_clock);
        conv_value <= v;
        wait_rx();
        check(rx_word, want);
        if (on_wire) begin
            wait_marker(1'b1, c);
            check(wire_word, want);
            // leave just after a valid word, so the next value lands in a later frame
            wait_rx();
            check(rx_word, want);
        end
    endtask

    task automatic resync();
        int c;
        wait_marker(1'b1, c);
        repeat (200) @(posedge clock);
        sync_req <= 1'b1;
        sync_mark = frame_count;
        @(posedge clock);
        sync_req <= 1'b0;
        @(negedge clock);
        check(sync_busy, 1);
        check(rx_unsettled, 1);
        repeat (8) @(posedge clock);
        // second request inside the busy window must be ignored
        sync_req <= 1'b1;
        @(posedge clock);
        sync_req <= 1'b0;
        repeat (53) @(posedge clock);
        @(negedge clock);
        check(link_bus.frame_marker_in, 1);
        repeat (3) @(posedge clock);
        @(negedge clock);
        check(sync_busy, 0);
        wait_marker(1'b1, c);
        check(c >= 960 && c <= 1120, 1);
        check(conv_unsettled, 1);
    endtask

    task automatic settle_count();
        int n = 0;
        while (conv_unsettled !== 1'b0) begin
            @(negedge clock);
            n++;
            if (n > 70000) expired();
        end
        check((frame_count - sync_mark) >= 30 && (frame_count - sync_mark) <= 32, 1);
    endtask

    task automatic shared_roles();
        int c;
        for (int s = 0; s < 2; s++) begin
            @(posedge clock);
            cfg_shared <= 1'b1;
            cfg_slave <= s[0];
            wait_marker(1'b1, c);
            wait_marker(1'b0, c);
            repeat (512) @(negedge clock);
            check(link_bus.serial_format_select, 1);
            check(link_bus.time_slot_select, s[0]);
            check(link_bus.serial_result_oe, !s[0]);
            repeat (1024) @(negedge clock);
            check(link_bus.serial_result_oe, s[0]);
        end
    endtask

    initial begin
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        free_frames();
        enable_levels();
        wait_rx();
        word_check(24'h123456, 1'b0);
        word_check(24'hedcba9, 1'b0);
        @(posedge clock);
        cfg_format_high <= 1'b1;
        wait_rx();
        wait_rx();
        resync();
        wait_rx();
        word_check(24'h001280, 1'b1);
        word_check(24'h00127f, 1'b1);
        word_check(24'hffff80, 1'b1);
        word_check(24'hfffe80, 1'b1);
        word_check(24'h7fff80, 1'b1);
        word_check(24'h800000, 1'b1);
        word_check(24'h7fffff, 1'b1);
        settle_count();
        shared_roles();
        report_and_stop();
    end
endmodule
